// file: hdl/cbs_regs.svh
// Constants of the bus cycle sequencer: register offsets, reset values, opcodes.
// Included by the package users; holds definitions only.
`ifndef CBS_REGS_SVH
`define CBS_REGS_SVH

// Avalon word indexes of the software registers.
`define CBS_OFF_CTRL     2'h0
`define CBS_OFF_STATUS   2'h1
`define CBS_OFF_DATAPATH 2'h2
`define CBS_OFF_MODULE   2'h3

// Reset values.
`define CBS_RUN_RST      1'h1
`define CBS_PC_RST       11'h000
`define CBS_IMAGE_RST    3'h0

// Working register file geometry and special operand values.
`define CBS_NUM_REGS     48
`define CBS_OPND_DIRECT_MAX 4'hb
`define CBS_OPND_INDIRECT   4'hc
`define CBS_OPND_DEC        4'hd
`define CBS_OPND_INC        4'he

// Opcodes and opcode groups.
`define CBS_OP_RETURN    8'h00
`define CBS_OP_STORE_Y   8'h8b
`define CBS_GRP_LOAD_ROW 5'h05
`define CBS_GRP_LOAD_PLN 5'h07
`define CBS_GRP_JUMP     2'h1
`define CBS_NIB_LOAD     4'hc
`define CBS_NIB_STORE    4'hd
`define CBS_NIB_BCD_ADD  4'he
`define CBS_JC_ALWAYS    3'h0
`define CBS_JC_ZERO      3'h1
`define CBS_JC_NONZERO   3'h2
`define CBS_JC_POSITIVE  3'h3
`define CBS_JC_ROW_NOT7  3'h4
`define CBS_JC_CARRY     3'h5
`define CBS_JC_NO_CARRY  3'h6
`define CBS_JC_CALL      3'h7

// Decimal correction constants.
`define CBS_BCD_BIAS     5'h06
`define CBS_BCD_UNBIAS   4'ha

// Control line codes: io strobe, data/address, counter/pointer, stack move.
`define CBS_CTL_IDLE     4'h0
`define CBS_CTL_JUMP     4'hc
`define CBS_CTL_CALL     4'hd
`define CBS_CTL_RETURN   4'h5
`define CBS_CTL_BCD      4'h4

`endif

// file: hdl/cbs_pkg.sv
// Types shared by the bus cycle sequencer modules.
// Assumes the shared constants header for the register file depth.
`include "cbs_regs.svh"
package cbs_pkg;

    typedef enum logic [1:0] {
        CBS_FETCH,
        CBS_EXEC1,
        CBS_EXEC2
    } cbs_phase_e;

    typedef struct packed {
        cbs_phase_e  phase;
        logic [10:0] pc;
        logic [10:0] second_stack_entry;
        logic [10:0] third_stack_entry;
        logic [10:0] z;
        logic [7:0]  ir;
        logic [7:0]  p;
        logic [7:0]  acc;
        logic [7:0]  y;
        logic [7:0]  bcd;
        logic [2:0]  s;
        logic [2:0]  t;
        logic [2:0]  image;
        logic        low_digit_carry;
        logic        high_digit_carry;
        logic        zf;
        logic        pf;
        logic [3:0]  ctl;
        logic        run;
        logic        waitreq;
        logic [31:0] rdata;
    } cbs_seq_s;

    typedef struct packed {
        logic [`CBS_NUM_REGS-1:0][7:0] mem;
        logic [7:0]                    rd;
    } cbs_rf_s;

endpackage

// file: hdl/cbs_rf_if.sv
// Port group between the sequencer and its working register file.
// Both ends run on the same clock.
`timescale 1ns/1ps
interface cbs_rf_if;
    logic [5:0] rd_addr;
    logic [7:0] rd_data;
    logic       wr_en;
    logic [5:0] wr_addr;
    logic [7:0] wr_data;

    modport seq (output rd_addr, output wr_en, output wr_addr, output wr_data, input rd_data);
    modport mem (input rd_addr, input wr_en, input wr_addr, input wr_data, output rd_data);
endinterface

// file: hdl/cbs_regfile.sv
// Working register file of 48 bytes with a registered read port.
// Assumes one clock; addresses at or above 48 read zero and ignore writes.
`timescale 1ns/1ps
`include "cbs_regs.svh"
module cbs_regfile
    import cbs_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_rst_b,
    cbs_rf_if.mem     rf
);
    cbs_rf_s q;
    cbs_rf_s d;

    always_comb
    begin
        d = q;
        d.rd = (rf.rd_addr < 6'(`CBS_NUM_REGS)) ? q.mem[rf.rd_addr] : 8'h00;
        if (rf.wr_en && rf.wr_addr < 6'(`CBS_NUM_REGS))
        begin
            d.mem[rf.wr_addr] = rf.wr_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign rf.rd_data = q.rd;
endmodule

// file: hdl/cbs_sequencer.sv
// Function
// - Fetch loads instruction latch and data buffer together.
// - Program counter increments after every fetched word.
// - Jump target from latch bits 0-2 and buffer.
// - Six conditional jumps on flags and row pointer.
// - Taken conditional jump behaves as three-cycle jump.
// - Failed condition finishes in two cycles, sequential.
// - Call pushes stack, then loads target address.
// - Operand 0-11 addresses working register directly.
// - Operand 12 accesses indirect register, pointers unchanged.
// - Operand 13 accesses indirect, then decrements row.
// - Operand 14 accesses indirect, then increments row.
// - Bank image copied from register bits 3-5.
// - Bank image drives upper address lines.
// - BCD add sets both carries in cycle one.
// - BCD add corrects result in cycle two.
// - Named flags update from same-cycle data lines.
// - Four control lines driven every cycle.
// - Row 0-7 and plane select indirect register.
// - Operand 15 direct access left unsupported.
//
// Instruction sequencer of an 8-bit processor with an Avalon-MM register slave.
// Assumes program memory answers combinationally on i_rom_data in the same clock domain.
//
// Local design decisions: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`include "cbs_regs.svh"
module cbs_sequencer
    import cbs_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire logic [7:0]  i_rom_data,
    output logic      [10:0] o_rom_addr,
    output logic      [2:0]  o_upper_address_line,
    output logic             o_io_strobe_control,
    output logic             o_data_or_address_select,
    output logic             o_counter_pointer_select,
    output logic             o_stack_move_control,
    input  wire logic [1:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest
);
    localparam cbs_seq_s SEQ_RST = '{phase: CBS_FETCH, pc: `CBS_PC_RST, image: `CBS_IMAGE_RST,
                                     run: `CBS_RUN_RST, waitreq: 1'b1, default: '0};

    cbs_seq_s q;
    cbs_seq_s d;
    cbs_rf_if rf ();

    cbs_regfile u_regfile (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .rf      (rf.mem)
    );

    // Operand 15 falls into the indirect branch; its effect is left undefined.
    function automatic logic [5:0] reg_index(input logic [3:0] nib, input logic [2:0] s, input logic [2:0] t);
        reg_index = (nib <= `CBS_OPND_DIRECT_MAX) ? {2'h0, nib} : {t, s};
    endfunction

    function automatic logic [2:0] row_after(input logic [3:0] nib, input logic [2:0] s);
        row_after = s;
        if (nib == `CBS_OPND_DEC)
        begin
            row_after = s - 3'h1;
        end
        else if (nib == `CBS_OPND_INC)
        begin
            row_after = s + 3'h1;
        end
    endfunction

    function automatic logic [3:0] ctl_of(input cbs_phase_e ph, input logic [7:0] ir);
        ctl_of = `CBS_CTL_IDLE;
        if (ph == CBS_EXEC2 && ir[7:6] == `CBS_GRP_JUMP)
        begin
            ctl_of = (ir[5:3] == `CBS_JC_CALL) ? `CBS_CTL_CALL : `CBS_CTL_JUMP;
        end
        else if (ph == CBS_EXEC1 && ir == `CBS_OP_RETURN)
        begin
            ctl_of = `CBS_CTL_RETURN;
        end
        else if (ph == CBS_EXEC1 && ir[7:4] == `CBS_NIB_BCD_ADD)
        begin
            ctl_of = `CBS_CTL_BCD;
        end
    endfunction

    logic       is_jump;
    logic       taken;
    logic [4:0] lo_sum;
    logic [4:0] hi_sum;
    logic [7:0] corrected;

    assign is_jump = (q.ir[7:6] == `CBS_GRP_JUMP);

    always_comb
    begin
        unique case (q.ir[5:3])
            `CBS_JC_ALWAYS:   taken = 1'b1;
            `CBS_JC_ZERO:     taken = q.zf;
            `CBS_JC_NONZERO:  taken = !q.zf;
            `CBS_JC_POSITIVE: taken = q.pf;
            `CBS_JC_ROW_NOT7: taken = !(&q.s);
            `CBS_JC_CARRY:    taken = q.high_digit_carry;
            `CBS_JC_NO_CARRY: taken = !q.high_digit_carry;
            `CBS_JC_CALL:     taken = 1'b1;
        endcase
    end

    // Each digit is biased by six so that its carry out is the decimal carry.
    assign lo_sum = {1'b0, rf.rd_data[3:0]} + {1'b0, q.acc[3:0]} + {4'h0, q.high_digit_carry} + `CBS_BCD_BIAS;
    assign hi_sum = {1'b0, rf.rd_data[7:4]} + {1'b0, q.acc[7:4]} + {4'h0, lo_sum[4]} + `CBS_BCD_BIAS;
    assign corrected = {q.high_digit_carry ? q.bcd[7:4] : q.bcd[7:4] + `CBS_BCD_UNBIAS,
                        q.low_digit_carry ? q.bcd[3:0] : q.bcd[3:0] + `CBS_BCD_UNBIAS};

    // The read address is taken from the bus during fetch so the operand is ready one cycle later.
    assign rf.rd_addr = reg_index((q.phase == CBS_FETCH) ? i_rom_data[3:0] : q.ir[3:0], q.s, q.t);

    always_comb
    begin
        d = q;
        rf.wr_en = 1'b0;
        rf.wr_addr = reg_index(q.ir[3:0], q.s, q.t);
        rf.wr_data = q.acc;
        if (q.run)
        begin
            unique case (q.phase)
                CBS_FETCH:
                begin
                    d.ir = i_rom_data;
                    d.p = i_rom_data;
                    d.pc = q.pc + 11'h1;
                    d.phase = CBS_EXEC1;
                end
                CBS_EXEC1:
                begin
                    d.phase = CBS_FETCH;
                    if (is_jump)
                    begin
                        d.p = i_rom_data;
                        d.pc = q.pc + 11'h1;
                        d.phase = taken ? CBS_EXEC2 : CBS_FETCH;
                    end
                    else if (q.ir == `CBS_OP_RETURN)
                    begin
                        d.pc = q.second_stack_entry;
                        d.second_stack_entry = q.third_stack_entry;
                    end
                    else if (q.ir == `CBS_OP_STORE_Y)
                    begin
                        d.y = q.acc;
                        d.image = q.acc[5:3];
                    end
                    else if (q.ir[7:3] == `CBS_GRP_LOAD_ROW)
                    begin
                        d.s = q.ir[2:0];
                    end
                    else if (q.ir[7:3] == `CBS_GRP_LOAD_PLN)
                    begin
                        d.t = q.ir[2:0];
                    end
                    else if (q.ir[7:4] == `CBS_NIB_LOAD)
                    begin
                        d.acc = rf.rd_data;
                        d.zf = (rf.rd_data == 8'h00);
                        d.pf = !rf.rd_data[7];
                        d.s = row_after(q.ir[3:0], q.s);
                    end
                    else if (q.ir[7:4] == `CBS_NIB_STORE)
                    begin
                        rf.wr_en = 1'b1;
                        d.s = row_after(q.ir[3:0], q.s);
                    end
                    else if (q.ir[7:4] == `CBS_NIB_BCD_ADD)
                    begin
                        d.bcd = {hi_sum[3:0], lo_sum[3:0]};
                        d.low_digit_carry = lo_sum[4];
                        d.high_digit_carry = hi_sum[4];
                        d.phase = CBS_EXEC2;
                    end
                end
                CBS_EXEC2:
                begin
                    d.phase = CBS_FETCH;
                    if (is_jump)
                    begin
                        if (q.ir[5:3] == `CBS_JC_CALL)
                        begin
                            d.z = q.third_stack_entry;
                            d.third_stack_entry = q.second_stack_entry;
                            d.second_stack_entry = q.pc;
                        end
                        d.pc = {q.ir[2:0], q.p};
                    end
                    else
                    begin
                        rf.wr_en = 1'b1;
                        rf.wr_data = corrected;
                        d.s = row_after(q.ir[3:0], q.s);
                    end
                end
            endcase
        end
        d.ctl = q.run ? ctl_of(d.phase, d.ir) : `CBS_CTL_IDLE;

        // Avalon slave: one wait state, then the access completes.
        d.waitreq = 1'b1;
        if ((i_avs_read || i_avs_write) && q.waitreq)
        begin
            d.waitreq = 1'b0;
            unique case (i_avs_address)
                `CBS_OFF_CTRL:     d.rdata = {31'h0, q.run};
                `CBS_OFF_STATUS:   d.rdata = {10'h0, q.phase, q.pf, q.zf, q.high_digit_carry, q.low_digit_carry,
                                              1'b0, q.image, 1'b0, q.pc};
                `CBS_OFF_DATAPATH: d.rdata = {8'h0, q.ir, 1'b0, q.t, 1'b0, q.s, q.acc};
                `CBS_OFF_MODULE:   d.rdata = {24'h0, q.y};
            endcase
        end
        if (i_avs_write && !q.waitreq)
        begin
            if (i_avs_address == `CBS_OFF_CTRL)
            begin
                d.run = i_avs_writedata[0];
            end
            else if (i_avs_address == `CBS_OFF_MODULE)
            begin
                d.y = i_avs_writedata[7:0];
                d.image = i_avs_writedata[5:3];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            q <= SEQ_RST;
        end
        else
        begin
            q <= d;
        end
    end

    assign o_rom_addr = q.pc;
    assign o_upper_address_line = q.image;
    assign o_io_strobe_control = q.ctl[3];
    assign o_data_or_address_select = q.ctl[2];
    assign o_counter_pointer_select = q.ctl[1];
    assign o_stack_move_control = q.ctl[0];
    assign o_avs_readdata = q.rdata;
    assign o_avs_waitrequest = q.waitreq;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);

    logic exec1_jump;
    assign exec1_jump = q.run && q.phase == CBS_EXEC1 && is_jump && q.ir[5:3] != `CBS_JC_CALL;

    sequence s_fetch;
        q.run && q.phase == CBS_FETCH;
    endsequence

    sequence s_taken_tail;
        q.phase == CBS_EXEC2 ##1 q.phase == CBS_FETCH;
    endsequence

    property p_fetch_latch;
        s_fetch |=> q.ir == $past(i_rom_data) && q.p == $past(i_rom_data);
    endproperty
    a_fetch_latch: assert property (p_fetch_latch) else $error("fetch did not fill latch and buffer");

    property p_pc_step;
        s_fetch |=> q.pc == $past(q.pc) + 11'h1;
    endproperty
    a_pc_step: assert property (p_pc_step) else $error("pc did not step after fetch");

    property p_jump_target;
        q.run && q.phase == CBS_EXEC2 && is_jump |=> q.pc == {$past(q.ir[2:0]), $past(q.p)};
    endproperty
    a_jump_target: assert property (p_jump_target) else $error("jump target wrong");

    property p_taken_three;
        exec1_jump && taken ##1 q.run |-> s_taken_tail;
    endproperty
    a_taken_three: assert property (p_taken_three) else $error("taken jump not three cycles");

    property p_fail_two;
        exec1_jump && !taken |=> q.phase == CBS_FETCH && q.pc == $past(q.pc) + 11'h1;
    endproperty
    a_fail_two: assert property (p_fail_two) else $error("failed jump not sequential");

    property p_call_push;
        q.run && q.phase == CBS_EXEC2 && is_jump && q.ir[5:3] == `CBS_JC_CALL
            |=> q.second_stack_entry == $past(q.pc) && q.third_stack_entry == $past(q.second_stack_entry)
                && q.z == $past(q.third_stack_entry);
    endproperty
    a_call_push: assert property (p_call_push) else $error("call push wrong");

    property p_row_dec;
        q.run && q.phase == CBS_EXEC1 && q.ir[7:4] == `CBS_NIB_LOAD && q.ir[3:0] == `CBS_OPND_DEC
            |=> q.s == $past(q.s) - 3'h1;
    endproperty
    a_row_dec: assert property (p_row_dec) else $error("row not decremented");

    property p_upper_lines;
        $changed(o_upper_address_line)
            |-> $past(q.run && q.phase == CBS_EXEC1 && q.ir == `CBS_OP_STORE_Y)
                || $past(i_avs_write && !q.waitreq && i_avs_address == `CBS_OFF_MODULE);
    endproperty
    a_upper_lines: assert property (p_upper_lines) else $error("upper lines not bank image");

    property p_bcd_carry;
        q.run && q.phase == CBS_EXEC1 && q.ir[7:4] == `CBS_NIB_BCD_ADD
            |=> q.high_digit_carry == $past(hi_sum[4]) && q.low_digit_carry == $past(lo_sum[4])
                && q.phase == CBS_EXEC2;
    endproperty
    a_bcd_carry: assert property (p_bcd_carry) else $error("bcd carries wrong");

    property p_return_pop;
        q.run && q.phase == CBS_EXEC1 && q.ir == `CBS_OP_RETURN
            |=> q.pc == $past(q.second_stack_entry) && q.second_stack_entry == $past(q.third_stack_entry);
    endproperty
    a_return_pop: assert property (p_return_pop) else $error("return pop wrong");
endmodule

// file: testbench/cbs_rom_model.sv
// Behavioural program memory that answers the sequencer's program bus.
// Assumes the bench preloads mem and that reads settle in the same clock cycle.
`timescale 1ns/1ps
module cbs_rom_model
(
    input  wire logic [2:0]  i_page,
    input  wire logic [10:0] i_addr,
    output logic      [7:0]  o_data
);
    logic [7:0] mem [0:16383];

    // The bank image picks a 2K page and the counter picks the word inside it.
    assign o_data = mem[{i_page, i_addr}];
endmodule

// file: testbench/cpu_bus_cycle_sequencer_test.sv
// Self-checking bench for the bus cycle sequencer with a program memory model.
// Assumes the register offsets, opcodes and control codes of the shared header.
`timescale 1ns/1ps
`include "cbs_regs.svh"
module cpu_bus_cycle_sequencer_test;
    import cbs_pkg::*;

    logic        i_clk = 1'h0;
    logic        rst_b = 1'h0;
    logic [7:0]  rom_data;
    logic [10:0] rom_addr;
    logic [2:0]  upper;
    logic        io_s;
    logic        da_s;
    logic        cp_s;
    logic        sm_s;
    logic [3:0]  ctl;
    logic [1:0]  avs_address = 2'h0;
    logic        avs_read = 1'h0;
    logic        avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    int          bad_count = 0;
    int          comparisons = 0;
    int          cycles = 0;

    assign ctl = {io_s, da_s, cp_s, sm_s};

    always #10 i_clk = ~i_clk;

    cbs_sequencer dut (
        .i_clk                    (i_clk),
        .i_rst_b                  (rst_b),
        .i_rom_data               (rom_data),
        .o_rom_addr               (rom_addr),
        .o_upper_address_line     (upper),
        .o_io_strobe_control      (io_s),
        .o_data_or_address_select (da_s),
        .o_counter_pointer_select (cp_s),
        .o_stack_move_control     (sm_s),
        .i_avs_address            (avs_address),
        .i_avs_read               (avs_read),
        .i_avs_write              (avs_write),
        .i_avs_writedata          (avs_writedata),
        .o_avs_readdata           (avs_readdata),
        .o_avs_waitrequest        (avs_waitrequest)
    );

    cbs_rom_model rom_model (
        .i_page (upper),
        .i_addr (rom_addr),
        .o_data (rom_data)
    );

    task automatic tally_and_finish();
        if (bad_count == 0 && comparisons > 0)
        begin
            $display("== PASSED ==");
        end
        else
        begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // The whole run needs a few hundred cycles; a hang is stopped here, far above that.
    always @(posedge i_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            bad_count++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] expected);
        comparisons++;
        if (seen !== expected)
        begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, expected);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task automatic fill(input logic [2:0] page, input logic [7:0] val);
        for (int i = 0; i < 2048; i++)
            rom_model.mem[{page, 11'(i)}] = val;
    endtask

    // Reset is asserted for three edges; the first fetch follows the release edge.
    task automatic do_reset();
        @(posedge i_clk);
        rst_b <= 1'h0;
        repeat (2) @(posedge i_clk);
        #1;
        check(rom_addr, `CBS_PC_RST);
        check(ctl, `CBS_CTL_IDLE);
        check(avs_waitrequest, 1'h1);
        @(posedge i_clk);
        rst_b <= 1'h1;
        #1;
    endtask

    task automatic av_write(input logic [1:0] addr, input logic [31:0] data);
        @(posedge i_clk);
        avs_address   <= addr;
        avs_writedata <= data;
        avs_write     <= 1'h1;
        @(posedge i_clk iff avs_waitrequest === 1'h0);
        avs_write <= 1'h0;
    endtask

    task automatic av_read(input logic [1:0] addr, output logic [31:0] data);
        @(posedge i_clk);
        avs_address <= addr;
        avs_read    <= 1'h1;
        @(posedge i_clk iff avs_waitrequest === 1'h0);
        data = avs_readdata;
        avs_read <= 1'h0;
    endtask

    task automatic wait_addr(input logic [10:0] a);
        int n;
        n = 0;
        while (rom_addr !== a && n < 64)
        begin
            step(1);
            n++;
        end
        check(rom_addr, a);
    endtask

    // Plane 6 reads as zero, so the load sets the zero flag and the BCD add
    // of zeros leaves the high carry clear; the row load settles the row test.
    task automatic test_cond(input logic [2:0] code, input logic [7:0] row_op, input logic taken);
        fill(3'h0, 8'hff);
        rom_model.mem[0] = 8'h3e;
        rom_model.mem[1] = 8'hcc;
        rom_model.mem[2] = 8'hec;
        rom_model.mem[3] = row_op;
        rom_model.mem[4] = {`CBS_GRP_JUMP, code, 3'h5};
        rom_model.mem[5] = 8'h34;
        rom_model.mem[14'h534] = `CBS_OP_RETURN;
        do_reset();
        wait_addr(11'h004);
        step(3);
        check(rom_addr, 11'h006);
        check(ctl, taken ? (code == `CBS_JC_CALL ? `CBS_CTL_CALL : `CBS_CTL_JUMP) : `CBS_CTL_IDLE);
        step(1);
        check(rom_addr, taken ? 11'h534 : 11'h007);
        if (code == `CBS_JC_CALL)
        begin
            step(1);
            check(ctl, `CBS_CTL_RETURN);
            wait_addr(11'h006);
        end
    endtask

    // Row 3, two post-decrements, one post-increment, one plain indirect: row 2.
    task automatic test_pointers();
        logic [31:0] rd;
        fill(3'h0, 8'hff);
        rom_model.mem[0] = 8'h38;
        rom_model.mem[1] = 8'h2b;
        rom_model.mem[2] = 8'hcd;
        rom_model.mem[3] = 8'hcd;
        rom_model.mem[4] = 8'hce;
        rom_model.mem[5] = 8'hcc;
        rom_model.mem[6] = 8'h40;
        rom_model.mem[7] = 8'h06;
        do_reset();
        wait_addr(11'h006);
        av_write(`CBS_OFF_DATAPATH, 32'h0);
        av_read(`CBS_OFF_DATAPATH, rd);
        check(rd[10:8], 3'h2);
        check(rd[14:12], 3'h0);
        check(rd[23:16], 8'h40);
    endtask

    // Page 5 holds only jumps to 0x747; page 0 holds no-ops, so reaching it
    // quickly proves the words come from the page named by the image.
    task automatic test_bank();
        logic [31:0] rd;
        fill(3'h0, 8'hff);
        fill(3'h5, 8'h47);
        do_reset();
        av_read(`CBS_OFF_CTRL, rd);
        check(rd[0], `CBS_RUN_RST);
        check(upper, `CBS_IMAGE_RST);
        av_write(`CBS_OFF_STATUS, 32'h0);
        av_write(`CBS_OFF_MODULE, 32'h28);
        step(1);
        check(upper, 3'h5);
        wait_addr(11'h747);
        av_read(`CBS_OFF_STATUS, rd);
        check(rd[14:12], 3'h5);
        av_read(`CBS_OFF_MODULE, rd);
        check(rd[7:0], 8'h28);
        // Clearing run must freeze the counter and quiet the control lines.
        av_write(`CBS_OFF_CTRL, 32'h0);
        step(1);
        rd = 32'(rom_addr);
        step(4);
        check(rom_addr, rd[10:0]);
        check(ctl, `CBS_CTL_IDLE);
    endtask

    initial
    begin
        for (int c = 0; c < 8; c++)
            test_cond(3'(c), 8'h2f, !(c == 2 || c == 4 || c == 5));
        test_cond(`CBS_JC_ROW_NOT7, 8'h28, 1'h1);
        test_pointers();
        test_bank();
        tally_and_finish();
    end
endmodule
